// file: rtl/scis_pkg.sv
/*
 * Package for the servo command input select block: register map, field
 * layouts, parameter encodings, timing figures and the state carrier types.
 * Assumes a single 10 MHz clock and an APB slave with 32-bit data.
 */
package scis_pkg;

    localparam int unsigned CLK_HZ        = 10_000_000;
    localparam int unsigned LD_MAX_PPS    = 500_000;
    localparam int unsigned OC_MAX_PPS    = 200_000;
    // Least clocks per step at the documented ceiling, rounded down
    localparam int unsigned LD_MIN_CYC    = CLK_HZ / LD_MAX_PPS;
    localparam int unsigned OC_MIN_CYC    = CLK_HZ / OC_MAX_PPS;

    localparam logic [7:0] ADDR_CFG0      = 8'h00;
    localparam logic [7:0] ADDR_CFG1      = 8'h04;
    localparam logic [7:0] ADDR_LIMITS    = 8'h08;
    localparam logic [7:0] ADDR_FILTERS   = 8'h0C;
    localparam logic [7:0] ADDR_POSITION  = 8'h10;
    localparam logic [7:0] ADDR_STATUS    = 8'h14;
    localparam logic [7:0] ADDR_ABSDATA   = 8'h18;

    localparam logic [31:0] CFG0_RESET    = 32'h0000_0000;
    localparam logic [31:0] CFG1_RESET    = 32'h0000_0000;
    localparam logic [31:0] LIMITS_RESET  = 32'h0000_0000;
    localparam logic [31:0] FILTERS_RESET = 32'h0000_0000;
    localparam logic [31:0] ZERO32        = 32'h0000_0000;

    localparam logic [1:0] SRC_OC         = 2'h0;
    localparam logic [1:0] FMT_CWCCW      = 2'h0;
    localparam logic [1:0] FMT_STEPDIR    = 2'h1;
    localparam logic [1:0] FMT_QUAD       = 2'h2;
    localparam logic [1:0] ZSD_OFF        = 2'h0;
    localparam logic [1:0] ZSD_CLAMP      = 2'h1;
    localparam logic [1:0] ZSD_DIR        = 2'h2;
    localparam logic [1:0] VFS_SWITCH     = 2'h1;
    localparam logic [1:0] TLS_SWITCH     = 2'h3;
    localparam logic [1:0] GIM_PI_P       = 2'h0;
    localparam logic [1:0] GIM_GAINSET    = 2'h1;
    localparam logic [1:0] TSL_TORQUE     = 2'h0;
    localparam logic [1:0] MODE_POSITION  = 2'h0;
    localparam logic [1:0] MODE_SPEED     = 2'h1;
    localparam logic [1:0] MODE_TORQUE    = 2'h2;

    localparam int unsigned NSYNC         = 10;
    localparam int unsigned S_A           = 0;
    localparam int unsigned S_B           = 1;
    localparam int unsigned S_REV_PERMIT  = 2;
    localparam int unsigned S_FWD_PERMIT  = 3;
    localparam int unsigned S_ZERO        = 4;
    localparam int unsigned S_DIR         = 5;
    localparam int unsigned S_VIB         = 6;
    localparam int unsigned S_GAIN        = 7;
    localparam int unsigned S_TLIM        = 8;
    localparam int unsigned S_ABSREQ      = 9;

    localparam logic [15:0] ONE16         = 16'h0001;
    localparam logic [5:0]  ABS_BITS      = 6'h20;
    localparam logic [5:0]  ONE6          = 6'h01;

    typedef enum logic [1:0] {
        SCIS_ABS_IDLE,
        SCIS_ABS_TURNS,
        SCIS_ABS_INCR,
        SCIS_ABS_DONE
    } scis_abs_t;

    typedef struct packed {
        logic [1:0] mode;
        logic [1:0] torque_speed_limit_source_param;
        logic [1:0] gain_input_mode_param;
        logic [1:0] torque_limit_select_param;
        logic [1:0] vib_filter_select_param;
        logic [1:0] zero_speed_dir_function_param;
        logic [1:0] step_format_param;
        logic [1:0] step_source_param;
    } scis_cfg_t;

    typedef struct packed {
        logic        fwd_block;
        logic        rev_block;
        logic        speed_zero;
        logic        speed_reverse;
        logic        filter_two;
        logic        p_only;
        logic        gain_two;
        logic        torque_limit_two;
        logic        analog_is_limit;
        logic [15:0] torque_limit;
    } scis_ctl_t;

    typedef struct packed {
        logic        sync_ok;
        logic [1:0]  sync_s;
        logic [15:0] gap;
        logic        overrate;
    } scis_rate_t;

endpackage : scis_pkg

// file: rtl/scis_top.sv
/*
 * Servo command input select: conditions the step command lines and the
 * discrete control inputs, decodes three step formats, applies travel
 * permits and parameter-gated selections, and serialises the absolute
 * position on request. Registers sit behind an APB slave.
 * Assumes all pins synchronous to mclk; the analog path and the encoder
 * itself lie outside, abs_turns and abs_incr are given by the encoder side.
 */
// The register offsets and register access over APB were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module scis_top
    import scis_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        resetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        cmd_line_a,
    input  wire logic        cmd_line_b,
    input  wire logic        oc_supply_a,
    input  wire logic        oc_supply_b,
    input  wire logic        reverse_travel_permit,
    input  wire logic        forward_travel_permit,
    input  wire logic        zero_speed_clamp_in,
    input  wire logic        speed_direction_in,
    input  wire logic        vibration_filter_switch_in,
    input  wire logic        gain_switch_in,
    input  wire logic        torque_limit_switch_in,
    input  wire logic        abs_position_request,
    input  wire logic [15:0] abs_turns,
    input  wire logic [15:0] abs_incr,
    output scis_ctl_t        ctl,
    output logic             abs_tx_data,
    output logic             abs_tx_valid,
    output logic             abs_tx_busy
);

    typedef struct packed {
        logic [NSYNC-1:0] s1;
        logic [NSYNC-1:0] s2;
        logic             a_d;
        logic             b_d;
        logic             req_d;
        scis_cfg_t        cfg;
        logic [31:0]      limits;
        logic [31:0]      filters;
        logic [31:0]      position;
        logic [15:0]      gap;
        logic             overrate;
        scis_ctl_t        ctl;
        scis_abs_t        abs_st;
        logic [31:0]      abs_sh;
        logic [5:0]       abs_cnt;
        logic             tx_data;
        logic             tx_valid;
        logic             tx_busy;
        logic [31:0]      prdata;
        logic             pready;
        logic             pslverr;
    } scis_state_t;

    scis_state_t st;
    scis_state_t next_st;

    logic [NSYNC-1:0] raw_in;
    logic             ph_a;
    logic             ph_b;
    logic             a_rise;
    logic             b_rise;
    logic             a_edge;
    logic             b_edge;
    logic             step_up;
    logic             step_dn;
    logic             apb_acc;
    logic [15:0]      min_gap;
    logic             apb_done;
    logic             too_fast;

    // Source choice ahead of the synchroniser so only one pair is tracked
    always_comb begin
        raw_in = '0;
        raw_in[S_A] = (st.cfg.step_source_param == SRC_OC) ? oc_supply_a : cmd_line_a;
        raw_in[S_B] = (st.cfg.step_source_param == SRC_OC) ? oc_supply_b : cmd_line_b;
        raw_in[S_REV_PERMIT] = reverse_travel_permit;
        raw_in[S_FWD_PERMIT] = forward_travel_permit;
        raw_in[S_ZERO]       = zero_speed_clamp_in;
        raw_in[S_DIR]        = speed_direction_in;
        raw_in[S_VIB]        = vibration_filter_switch_in;
        raw_in[S_GAIN]       = gain_switch_in;
        raw_in[S_TLIM]       = torque_limit_switch_in;
        raw_in[S_ABSREQ]     = abs_position_request;
    end

    assign ph_a    = st.s2[S_A];
    assign ph_b    = st.s2[S_B];
    assign a_rise  = ph_a & ~st.a_d;
    assign b_rise  = ph_b & ~st.b_d;
    assign a_edge  = ph_a ^ st.a_d;
    assign b_edge  = ph_b ^ st.b_d;
    assign apb_acc = psel & penable & ~st.pready;
    assign min_gap = (st.cfg.step_source_param == SRC_OC) ? 16'(OC_MIN_CYC) : 16'(LD_MIN_CYC);
    assign apb_done = psel & penable & st.pready;
    // Gap holds step spacing less one, so the rated ceiling itself passes
    assign too_fast = (step_up | step_dn) & (st.gap < min_gap - ONE16);

    // Step decode per format
    always_comb begin
        step_up = 1'b0;
        step_dn = 1'b0;
        case (st.cfg.step_format_param)
            FMT_CWCCW: begin
                step_dn = a_rise;
                step_up = b_rise;
            end
            FMT_STEPDIR: begin
                step_up = a_rise & ~ph_b;
                step_dn = a_rise & ph_b;
            end
            FMT_QUAD: begin
                // A leads: new A differs from B, or new B equals A
                step_up = (a_edge & (ph_a != ph_b)) | (b_edge & (ph_a == ph_b));
                step_dn = (a_edge & (ph_a == ph_b)) | (b_edge & (ph_a != ph_b));
                if (a_edge & b_edge) begin
                    step_up = 1'b0;
                    step_dn = 1'b0;
                end
            end
            default: begin
                step_up = 1'b0;
                step_dn = 1'b0;
            end
        endcase
        step_up = step_up & st.s2[S_FWD_PERMIT];
        step_dn = step_dn & st.s2[S_REV_PERMIT];
    end

    always_comb begin
        next_st = st;
        next_st.s1 = raw_in;
        next_st.s2 = st.s1;
        next_st.a_d = ph_a;
        next_st.b_d = ph_b;
        next_st.req_d = st.s2[S_ABSREQ];

        if (step_up) begin
            next_st.position = st.position + 32'h0000_0001;
        end else if (step_dn) begin
            next_st.position = st.position - 32'h0000_0001;
        end

        // Overrate is flagged further down; counting still proceeds
        if (step_up | step_dn) begin
            next_st.gap = '0;
        end else if (st.gap != 16'hFFFF) begin
            next_st.gap = st.gap + ONE16;
        end

        // Discrete selections
        next_st.ctl.fwd_block = ~st.s2[S_FWD_PERMIT];
        next_st.ctl.rev_block = ~st.s2[S_REV_PERMIT];
        next_st.ctl.speed_zero = 1'b0;
        next_st.ctl.speed_reverse = 1'b0;
        if (st.cfg.zero_speed_dir_function_param == ZSD_CLAMP
                && (st.cfg.mode == MODE_SPEED || st.cfg.mode == MODE_TORQUE)) begin
            next_st.ctl.speed_zero = ~st.s2[S_ZERO];
        end
        if (st.cfg.zero_speed_dir_function_param == ZSD_DIR && st.cfg.mode == MODE_SPEED) begin
            next_st.ctl.speed_reverse = st.s2[S_DIR];
        end
        next_st.ctl.filter_two = (st.cfg.vib_filter_select_param == VFS_SWITCH)
            && (st.cfg.mode == MODE_POSITION) && st.s2[S_VIB];
        next_st.ctl.p_only = (st.cfg.torque_limit_select_param != TLS_SWITCH)
            && (st.cfg.gain_input_mode_param == GIM_PI_P) && st.s2[S_GAIN];
        next_st.ctl.gain_two = (st.cfg.torque_limit_select_param != TLS_SWITCH)
            && (st.cfg.gain_input_mode_param == GIM_GAINSET) && st.s2[S_GAIN];
        next_st.ctl.torque_limit_two = (st.cfg.torque_limit_select_param == TLS_SWITCH)
            && st.s2[S_TLIM];
        next_st.ctl.torque_limit = next_st.ctl.torque_limit_two
            ? st.limits[31:16] : st.limits[15:0];
        next_st.ctl.analog_is_limit = (st.cfg.mode == MODE_TORQUE)
            && (st.cfg.torque_speed_limit_source_param != TSL_TORQUE);

        // Absolute position serialiser, turns word first
        next_st.tx_valid = 1'b0;
        case (st.abs_st)
            SCIS_ABS_IDLE: begin
                if (st.s2[S_ABSREQ] & ~st.req_d) begin
                    next_st.abs_st = SCIS_ABS_TURNS;
                    next_st.abs_sh = {abs_turns, abs_incr};
                    next_st.abs_cnt = '0;
                end
            end
            SCIS_ABS_TURNS, SCIS_ABS_INCR: begin
                next_st.tx_data = st.abs_sh[31];
                next_st.tx_valid = 1'b1;
                next_st.abs_sh = {st.abs_sh[30:0], 1'b0};
                next_st.abs_cnt = st.abs_cnt + ONE6;
                if (st.abs_cnt == (ABS_BITS >> 1) - ONE6) begin
                    next_st.abs_st = SCIS_ABS_INCR;
                end
                if (st.abs_cnt == ABS_BITS - ONE6) begin
                    next_st.abs_st = SCIS_ABS_DONE;
                end
            end
            SCIS_ABS_DONE: begin
                // Rearm only after the request drops
                if (~st.s2[S_ABSREQ]) begin
                    next_st.abs_st = SCIS_ABS_IDLE;
                end
            end
            default: next_st.abs_st = SCIS_ABS_IDLE;
        endcase
        // Busy is registered so the pin comes straight from a flop
        next_st.tx_busy = (next_st.abs_st == SCIS_ABS_TURNS)
            || (next_st.abs_st == SCIS_ABS_INCR);

        // APB: one wait state, answer in the second cycle after setup
        next_st.pready = apb_acc;
        next_st.pslverr = 1'b0;
        if (apb_acc) begin
            next_st.prdata = ZERO32;
            if (pwrite) begin
                // Only the answer here; the write itself waits for completion
                case (paddr)
                    ADDR_CFG0, ADDR_LIMITS, ADDR_FILTERS, ADDR_STATUS: next_st.pslverr = 1'b0;
                    default:      next_st.pslverr = 1'b1;
                endcase
            end else begin
                case (paddr)
                    ADDR_CFG0:     next_st.prdata = {16'h0000, st.cfg};
                    ADDR_CFG1:     next_st.prdata = ZERO32;
                    ADDR_LIMITS:   next_st.prdata = st.limits;
                    ADDR_FILTERS:  next_st.prdata = st.filters;
                    ADDR_POSITION: next_st.prdata = st.position;
                    ADDR_STATUS:   next_st.prdata = {22'h000000, st.s2[S_ABSREQ:S_REV_PERMIT],
                                                     st.abs_st != SCIS_ABS_IDLE, st.overrate};
                    ADDR_ABSDATA:  next_st.prdata = {abs_turns, abs_incr};
                    default:       next_st.pslverr = 1'b1;
                endcase
            end
        end
        // Writes land on the edge that sees pready high
        if (apb_done & pwrite) begin
            case (paddr)
                ADDR_CFG0:    next_st.cfg = scis_cfg_t'(pwdata[15:0]);
                ADDR_LIMITS:  next_st.limits = pwdata;
                ADDR_FILTERS: next_st.filters = pwdata;
                ADDR_STATUS:  next_st.overrate = st.overrate & ~pwdata[0];
                default: begin
                end
            endcase
        end
        // Overrate set wins over a same-cycle clear
        if (too_fast) begin
            next_st.overrate = 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            st <= '0;
            st.abs_st <= SCIS_ABS_IDLE;
            // Long idle at reset, so an early first step is never overrate
            st.gap <= '1;
            st.cfg <= scis_cfg_t'(CFG0_RESET[15:0]);
            st.limits <= LIMITS_RESET;
            st.filters <= FILTERS_RESET;
        end else begin
            st <= next_st;
        end
    end

    assign prdata       = st.prdata;
    assign pready       = st.pready;
    assign pslverr      = st.pslverr;
    assign ctl          = st.ctl;
    assign abs_tx_data  = st.tx_data;
    assign abs_tx_valid = st.tx_valid;
    assign abs_tx_busy  = st.tx_busy;

    a_fwd_block_follows: assert property (@(posedge mclk) disable iff (!resetn)
        $fell(st.s2[S_FWD_PERMIT]) |=> ctl.fwd_block)
        else $error("forward block did not follow permit");
    a_rev_step_blocked: assert property (@(posedge mclk) disable iff (!resetn)
        !st.s2[S_REV_PERMIT] |=> st.position <= $past(st.position) || $past(step_up))
        else $error("reverse step counted while blocked");
    a_zero_ignored: assert property (@(posedge mclk) disable iff (!resetn)
        st.cfg.zero_speed_dir_function_param == ZSD_OFF && $stable(st.cfg)
        |=> !ctl.speed_zero && !ctl.speed_reverse)
        else $error("clamp or direction acted with function off");
    a_clamp_zero: assert property (@(posedge mclk) disable iff (!resetn)
        st.cfg.zero_speed_dir_function_param == ZSD_CLAMP && st.cfg.mode == MODE_SPEED
        && !st.s2[S_ZERO] |=> ctl.speed_zero)
        else $error("speed not clamped");
    a_dir_reverse: assert property (@(posedge mclk) disable iff (!resetn)
        st.cfg.zero_speed_dir_function_param == ZSD_DIR && st.cfg.mode == MODE_SPEED
        && $stable(st.cfg) |=> ctl.speed_reverse == $past(st.s2[S_DIR]))
        else $error("direction not applied");
    a_tlim_select: assert property (@(posedge mclk) disable iff (!resetn)
        st.cfg.torque_limit_select_param == TLS_SWITCH && $stable(st.cfg)
        |=> ctl.torque_limit_two == $past(st.s2[S_TLIM]))
        else $error("torque limit select wrong");
    a_sync_depth: assert property (@(posedge mclk) disable iff (!resetn)
        ##2 st.s2[S_GAIN] == $past(gain_switch_in, 2))
        else $error("synchroniser depth wrong");
    a_abs_length: assert property (@(posedge mclk) disable iff (!resetn)
        $rose(abs_tx_busy) |-> abs_tx_busy [*8] ##25 !abs_tx_busy)
        else $error("absolute frame length wrong");
    a_quad_up: assert property (@(posedge mclk) disable iff (!resetn)
        st.cfg.step_format_param == FMT_QUAD && st.s2[S_FWD_PERMIT] && a_rise && !ph_b
        && !b_edge |=> st.position == $past(st.position) + 32'h0000_0001)
        else $error("quadrature up count missing");
    a_src_select: assert property (@(posedge mclk) disable iff (!resetn)
        st.cfg.step_source_param == SRC_OC |=> st.s1[S_A] == $past(oc_supply_a))
        else $error("open-collector line not selected");
    a_overrate_set: assert property (@(posedge mclk) disable iff (!resetn)
        too_fast |=> st.overrate)
        else $error("overrate not flagged");
    a_filter_select: assert property (@(posedge mclk) disable iff (!resetn)
        st.cfg.vib_filter_select_param == VFS_SWITCH && st.cfg.mode == MODE_POSITION
        |=> ctl.filter_two == $past(st.s2[S_VIB]))
        else $error("filter set not chosen by switch");
    a_p_only_mode: assert property (@(posedge mclk) disable iff (!resetn)
        st.cfg.torque_limit_select_param != TLS_SWITCH
        && st.cfg.gain_input_mode_param == GIM_PI_P
        |=> ctl.p_only == $past(st.s2[S_GAIN]) && !ctl.gain_two)
        else $error("proportional mode not following switch");
    a_gain_set: assert property (@(posedge mclk) disable iff (!resetn)
        st.cfg.torque_limit_select_param != TLS_SWITCH
        && st.cfg.gain_input_mode_param == GIM_GAINSET
        |=> ctl.gain_two == $past(st.s2[S_GAIN]) && !ctl.p_only)
        else $error("gain set not following switch");
    a_analog_limit: assert property (@(posedge mclk) disable iff (!resetn)
        st.cfg.mode == MODE_TORQUE
        |=> ctl.analog_is_limit == ($past(st.cfg.torque_speed_limit_source_param) != TSL_TORQUE))
        else $error("analog input role wrong");

endmodule : scis_top
`default_nettype wire

// file: verif/scis_ctrl_model.sv
/* Motion controller stand-in: drives the two step command lines in the
   chosen format. Assumes send is called just after a rising mclk edge. */
`timescale 1ns/1ps
`default_nettype none
module scis_ctrl_model
    import scis_pkg::*;
(
    input  wire logic mclk,
    output logic      line_a,
    output logic      line_b
);
    logic [1:0] ph = 2'h0;
    initial begin
        line_a = 1'b0;
        line_b = 1'b0;
    end
    // Gap is edge spacing; callers keep it at or above the source ceiling, except the overrate test, which uses 4
    task automatic send(input logic [1:0] fmt, input logic rev, input int n, input int gap);
        if (fmt == FMT_STEPDIR) begin
            line_b <= rev;
            repeat (gap) @(posedge mclk);
        end
        for (int i = 0; i < n; i++) begin
            if (fmt == FMT_QUAD) begin
                ph = rev ? ph - 2'h1 : ph + 2'h1;
                line_a <= ph[1] ^ ph[0];
                line_b <= ph[1];
                repeat (gap) @(posedge mclk);
            end else begin
                line_a <= (fmt == FMT_STEPDIR) | rev;
                if (fmt != FMT_STEPDIR) line_b <= !rev;
                repeat (gap) @(posedge mclk);
                line_a <= 1'b0;
                if (fmt != FMT_STEPDIR) line_b <= 1'b0;
                repeat (gap) @(posedge mclk);
            end
        end
        // Direction level dropped so a later format sees quiet lines
        if (fmt != FMT_QUAD) line_b <= 1'b0;
        repeat (12) @(posedge mclk);
    endtask
endmodule // scis_ctrl_model
`default_nettype wire

// file: verif/servo_command_input_select_tb.sv
/* Self-checking bench for scis_top: APB tasks, step traffic from the
   controller model, input selections and the absolute position dump.
   Assumes scis_pkg and scis_ctrl_model are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module servo_command_input_select_tb
    import scis_pkg::*;
;
    logic        mclk, resetn, psel, penable, pwrite, to_ld, absrq;
    logic        pready, pslverr, m_a, m_b, tx_d, tx_v, tx_busy;
    logic [7:0]  paddr;
    logic [6:0]  din;
    logic [31:0] pwdata, prdata, pos, d, w;
    scis_ctl_t   ctl;
    int          mismatches, checks, n, t, nb;

    scis_top scis_top_inst (
        .mclk(mclk), .resetn(resetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr),
        .cmd_line_a(to_ld & m_a), .cmd_line_b(to_ld & m_b),
        .oc_supply_a(!to_ld & m_a), .oc_supply_b(!to_ld & m_b),
        .reverse_travel_permit(din[6]), .forward_travel_permit(din[5]),
        .zero_speed_clamp_in(din[4]), .speed_direction_in(din[3]),
        .vibration_filter_switch_in(din[2]), .gain_switch_in(din[1]),
        .torque_limit_switch_in(din[0]), .abs_position_request(absrq),
        .abs_turns(16'hA5C3), .abs_incr(16'h3C5A), .ctl(ctl),
        .abs_tx_data(tx_d), .abs_tx_valid(tx_v), .abs_tx_busy(tx_busy)
    );
    scis_ctrl_model scis_ctrl_model_inst (.mclk(mclk), .line_a(m_a), .line_b(m_b));

    task automatic print_verdict();
        $display("checks=%0d mismatches=%0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, input logic ee);
        int k;
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= wd;
        @(posedge mclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge mclk);
            k++;
        end while (pready !== 1'b1 && k < 40);
        if (pready !== 1'b1) begin
            mismatches++;
            print_verdict();
        end
        rd = prdata;
        chk({31'h0, pslverr}, {31'h0, ee});
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
    endtask
    // Cfg is the low half of CFG0, laid out as scis_cfg_t
    task automatic sel(input logic [15:0] cfg, input logic [6:0] v, input logic [8:0] e);
        logic [31:0] q;
        apb(1'b1, ADDR_CFG0, {16'h0000, cfg}, q, 1'b0);
        din <= v;
        repeat (6) @(negedge mclk);
        chk({23'h0, ctl[24:16]}, {23'h0, e});
        @(posedge mclk);
    endtask

    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    initial begin
        repeat (40000) @(posedge mclk);
        mismatches++;
        print_verdict();
    end
    initial begin
        {resetn, psel, penable, pwrite, to_ld, absrq} = 6'h00;
        {paddr, pwdata, din, pos, w} = '0;
        repeat (8) @(posedge mclk);
        resetn <= 1'b1;
        @(posedge mclk);
        apb(1'b0, ADDR_CFG0, ZERO32, d, 1'b0);
        chk(d, CFG0_RESET);
        apb(1'b0, ADDR_LIMITS, ZERO32, d, 1'b0);
        chk(d, LIMITS_RESET);
        apb(1'b1, ADDR_CFG1, 32'h0000_FFFF, d, 1'b1);
        apb(1'b0, ADDR_CFG1, ZERO32, d, 1'b0);
        chk(d, ZERO32);
        apb(1'b0, 8'h1C, ZERO32, d, 1'b1);
        din <= 7'h60;
        for (int s = 0; s < 2; s++) begin
            for (int f = 0; f < 3; f++) begin
                to_ld <= s[0];
                apb(1'b1, ADDR_CFG0, {28'h0, f[1:0], 1'b0, s[0]}, d, 1'b0);
                for (int r = 0; r < 2; r++) begin
                    scis_ctrl_model_inst.send(f[1:0], r[0], 8, s ? LD_MIN_CYC : OC_MIN_CYC);
                    pos = r ? pos - 32'h8 : pos + 32'h8;
                    apb(1'b0, ADDR_POSITION, ZERO32, d, 1'b0);
                    chk(d, pos);
                end
            end
        end
        apb(1'b1, ADDR_CFG0, ZERO32, d, 1'b0);
        scis_ctrl_model_inst.send(FMT_CWCCW, 1'b0, 8, OC_MIN_CYC);
        apb(1'b0, ADDR_POSITION, ZERO32, d, 1'b0);
        chk(d, pos);
        apb(1'b1, ADDR_CFG0, 32'h0000_0001, d, 1'b0);
        apb(1'b0, ADDR_STATUS, ZERO32, d, 1'b0);
        chk(d & 32'h1, ZERO32);
        scis_ctrl_model_inst.send(FMT_CWCCW, 1'b0, 2, 4);
        apb(1'b0, ADDR_STATUS, ZERO32, d, 1'b0);
        chk(d & 32'h1, 32'h1);
        apb(1'b1, ADDR_STATUS, 32'h1, d, 1'b0);
        apb(1'b0, ADDR_STATUS, ZERO32, d, 1'b0);
        chk(d & 32'h1, ZERO32);
        pos = pos + 32'h2;
        din <= 7'h20;
        repeat (4) @(posedge mclk);
        scis_ctrl_model_inst.send(FMT_CWCCW, 1'b1, 4, LD_MIN_CYC);
        din <= 7'h40;
        repeat (4) @(posedge mclk);
        scis_ctrl_model_inst.send(FMT_CWCCW, 1'b0, 4, LD_MIN_CYC);
        apb(1'b0, ADDR_POSITION, ZERO32, d, 1'b0);
        chk(d, pos);
        apb(1'b1, ADDR_LIMITS, 32'h0222_0111, d, 1'b0);
        sel(16'h4000, 7'h20, 9'h080);
        sel(16'h4000, 7'h40, 9'h100);
        sel(16'h4000, 7'h68, 9'h000);
        sel(16'h4010, 7'h60, 9'h040);
        sel(16'h4010, 7'h70, 9'h000);
        sel(16'h8010, 7'h60, 9'h040);
        sel(16'h4020, 7'h78, 9'h020);
        sel(16'h4020, 7'h70, 9'h000);
        sel(16'h0040, 7'h64, 9'h010);
        sel(16'h0040, 7'h60, 9'h000);
        sel(16'h4000, 7'h62, 9'h008);
        sel(16'h4400, 7'h62, 9'h004);
        sel(16'h4300, 7'h61, 9'h002);
        chk({16'h0, ctl.torque_limit}, 32'h0222);
        sel(16'h4300, 7'h60, 9'h000);
        chk({16'h0, ctl.torque_limit}, 32'h0111);
        sel(16'h9000, 7'h60, 9'h001);
        sel(16'h8000, 7'h60, 9'h000);
        absrq <= 1'b1;
        n = 0;
        t = 0;
        nb = 0;
        while (n < 32 && t < 400) begin
            @(negedge mclk);
            t++;
            if (tx_busy === 1'b1) nb++;
            if (tx_v === 1'b1) begin
                w = {w[30:0], tx_d};
                n++;
            end
        end
        chk(w, 32'hA5C3_3C5A);
        chk(nb, 32'h20);
        @(posedge mclk);
        absrq <= 1'b0;
        print_verdict();
    end
endmodule // servo_command_input_select_tb
`default_nettype wire
